// ---- hw/tcmc_defines.vh ----
// Register offsets, field positions and reset values of the timer channel
`ifndef TCMC_DEFINES_VH
`define TCMC_DEFINES_VH
// ==========================================
// Register byte offsets
`define TCMC_CMD_OFS      8'h00
`define TCMC_MODE_OFS     8'h04
`define TCMC_VALUE_OFS    8'h10
`define TCMC_HOLD_A_OFS   8'h14
`define TCMC_HOLD_B_OFS   8'h18
`define TCMC_HOLD_C_OFS   8'h1C
`define TCMC_STATUS_OFS   8'h20
`define TCMC_XSEL_OFS     8'hC4
// ==========================================
// Command bits
`define TCMC_CLK_ON_BIT   0
`define TCMC_CLK_OFF_BIT  1
`define TCMC_SOFT_TRG_BIT 2
// ==========================================
// Mode fields shared by both views
`define TCMC_CLK_SEL_LSB  0
`define TCMC_INVERT_BIT   3
`define TCMC_GATE_LSB     4
`define TCMC_STOP_BIT     6
`define TCMC_DIS_BIT      7
`define TCMC_EDGE_LSB     8
`define TCMC_WAVE_BIT     15
// Capture view
`define TCMC_LINE_SEL_BIT 10
`define TCMC_CPC_TRG_BIT  14
`define TCMC_LOAD_A_LSB   16
`define TCMC_LOAD_B_LSB   18
// Waveform view
`define TCMC_EVT_SEL_LSB  10
`define TCMC_EVT_TRG_BIT  12
`define TCMC_SHAPE_LSB    13
`define TCMC_ACT_LSB      16
// ==========================================
// External clock select fields and status bits
`define TCMC_XC1_LSB      2
`define TCMC_XC2_LSB      4
`define TCMC_ST_CLK_BIT   16
`define TCMC_ST_IOA_BIT   17
`define TCMC_ST_IOB_BIT   18
// ==========================================
// Reset values and limits
`define TCMC_MODE_RST     32'h00000000
`define TCMC_XSEL_RST     6'h00
`define TCMC_CNT_MAX      16'hFFFF
`endif

// ---- hw/tcmc_channel.v ----
// One timer channel: command, mode, external clock select and counter core
`timescale 1ns/1ps
`include "tcmc_defines.vh"
module tcmc_channel #(
  parameter CW = 16                // Counter width
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  input  wire [4:0]  internal_clk,
  input  wire        ext_clk_0,
  input  wire        clock_pin_1,
  input  wire        clock_pin_2,
  input  wire        io_a_ch0,
  input  wire        io_a_ch1,
  input  wire        io_a_ch2,
  input  wire        io_line_a_in,
  output reg         io_line_a_out,
  output wire        io_line_a_oe,
  input  wire        io_line_b_in,
  output reg         io_line_b_out,
  output wire        io_line_b_oe
);

  // ==========================================
  // Helper functions
  // Edge filter: none, rising, falling, each
  function edge_hit;
    input [1:0] code;
    input       rise;
    input       fall;
    begin
      edge_hit = (code[0] & rise) | (code[1] & fall);
    end
  endfunction

  // Output action: none, set, clear, toggle
  function apply_act;
    input       lvl;
    input [1:0] code;
    input       hit;
    begin
      if (!hit) begin
        apply_act = lvl;
      end else begin
        case (code)
          2'b01:   apply_act = 1'b1;
          2'b10:   apply_act = 1'b0;
          2'b11:   apply_act = ~lvl;
          default: apply_act = lvl;
        endcase
      end
    end
  endfunction

  // ==========================================
  // State
  reg  [31:0]   mode_reg;          // Channel mode
  reg  [5:0]    xsel_reg;          // External clock mux selects
  reg  [CW-1:0] cv_reg;            // Counter value
  reg  [CW-1:0] hold_a_reg;        // Hold/compare a
  reg  [CW-1:0] hold_b_reg;        // Hold/compare b
  reg  [CW-1:0] hold_c_reg;        // Compare c
  reg           clk_en_reg;        // Counter clock enabled
  reg           stop_reg;          // Counter clock stopped
  reg           down_reg;          // Counting down in updown shape
  reg           step_reg;          // Counter ticked or was triggered last cycle
  reg           gclk_reg;          // Previous gated clock level
  reg           ioa_reg;           // Previous line_a input
  reg           iob_reg;           // Previous line_b input
  reg           xc0_reg;           // Previous external clocks
  reg           xc1_reg;
  reg           xc2_reg;

  // ==========================================
  // Bus decode
  wire       wr_acc = psel & penable & pwrite;
  wire       setup  = psel & ~penable;
  wire       wave   = mode_reg[`TCMC_WAVE_BIT];
  wire       cmd_wr = ce & wr_acc & (paddr == `TCMC_CMD_OFS);
  wire       on_cmd = cmd_wr & pwdata[`TCMC_CLK_ON_BIT];
  wire       off_cmd = cmd_wr & pwdata[`TCMC_CLK_OFF_BIT];
  wire       sw_trg = cmd_wr & pwdata[`TCMC_SOFT_TRG_BIT];

  // Zero wait states
  assign pready = 1'b1;

  // ==========================================
  // External clock multiplexers
  reg ext_clk_1;                   // Selected external clock 1
  reg ext_clk_2;                   // Selected external clock 2

  always @* begin
    case (xsel_reg[`TCMC_XC1_LSB +: 2])
      2'b00:   ext_clk_1 = clock_pin_1;
      2'b10:   ext_clk_1 = io_a_ch0;
      2'b11:   ext_clk_1 = io_a_ch2;
      default: ext_clk_1 = 1'b0;
    endcase
    case (xsel_reg[`TCMC_XC2_LSB +: 2])
      2'b00:   ext_clk_2 = clock_pin_2;
      2'b10:   ext_clk_2 = io_a_ch0;
      2'b11:   ext_clk_2 = io_a_ch1;
      default: ext_clk_2 = 1'b0;
    endcase
  end

  // ==========================================
  // Counting clock select, gating and edge
  reg sel_clk;                     // Selected clock level
  reg gate;                        // Gating level

  always @* begin
    case (mode_reg[`TCMC_CLK_SEL_LSB +: 3])
      3'h5:    sel_clk = ext_clk_0;
      3'h6:    sel_clk = ext_clk_1;
      3'h7:    sel_clk = ext_clk_2;
      default: sel_clk = internal_clk[mode_reg[`TCMC_CLK_SEL_LSB +: 3]];
    endcase
    case (mode_reg[`TCMC_GATE_LSB +: 2])
      2'b01:   gate = ext_clk_0;
      2'b10:   gate = ext_clk_1;
      2'b11:   gate = ext_clk_2;
      default: gate = 1'b1;
    endcase
  end

  wire gclk    = sel_clk & gate;
  wire running = clk_en_reg & ~stop_reg;
  // Rising edge normally, falling edge when inverted
  wire tick = running & (mode_reg[`TCMC_INVERT_BIT] ? (gclk_reg & ~gclk)
                                                    : (gclk & ~gclk_reg));

  // ==========================================
  // Line edges and event sources
  wire a_rise = io_line_a_in & ~ioa_reg;
  wire a_fall = ~io_line_a_in & ioa_reg;
  wire b_rise = io_line_b_in & ~iob_reg;
  wire b_fall = ~io_line_b_in & iob_reg;
  wire [1:0] edge_code = mode_reg[`TCMC_EDGE_LSB +: 2];

  // Capture trigger line: line_b at 0, line_a at 1
  wire ctrg = mode_reg[`TCMC_LINE_SEL_BIT] ? edge_hit(edge_code, a_rise, a_fall)
                                           : edge_hit(edge_code, b_rise, b_fall);

  // Waveform event source
  reg ev_rise;                     // Selected event rises
  reg ev_fall;                     // Selected event falls

  always @* begin
    case (mode_reg[`TCMC_EVT_SEL_LSB +: 2])
      2'b01: begin
        ev_rise = ext_clk_0 & ~xc0_reg;
        ev_fall = ~ext_clk_0 & xc0_reg;
      end
      2'b10: begin
        ev_rise = ext_clk_1 & ~xc1_reg;
        ev_fall = ~ext_clk_1 & xc1_reg;
      end
      2'b11: begin
        ev_rise = ext_clk_2 & ~xc2_reg;
        ev_fall = ~ext_clk_2 & xc2_reg;
      end
      default: begin
        ev_rise = b_rise;
        ev_fall = b_fall;
      end
    endcase
  end

  wire evt     = wave & edge_hit(edge_code, ev_rise, ev_fall);
  wire b_is_in = mode_reg[`TCMC_EVT_SEL_LSB +: 2] == 2'b00;

  // ==========================================
  // Compares, loads and triggers
  wire cmp_a = step_reg & (cv_reg == hold_a_reg);
  wire cmp_b = step_reg & (cv_reg == hold_b_reg);
  wire cmp_c = step_reg & (cv_reg == hold_c_reg);
  wire ld_a  = ~wave & edge_hit(mode_reg[`TCMC_LOAD_A_LSB +: 2], a_rise, a_fall);
  wire ld_b  = ~wave & edge_hit(mode_reg[`TCMC_LOAD_B_LSB +: 2], a_rise, a_fall);
  wire [1:0] shape = mode_reg[`TCMC_SHAPE_LSB +: 2];

  wire ext_trg = wave ? (evt & mode_reg[`TCMC_EVT_TRG_BIT])
                      : ctrg;
  wire cpc_trg = cmp_c & (wave ? shape[1]
                               : mode_reg[`TCMC_CPC_TRG_BIT]);
  wire trig    = sw_trg | ext_trg | cpc_trg;

  // Stop and disable events, in either view
  wire stop_evt = wave ? (mode_reg[`TCMC_STOP_BIT] & cmp_c)
                       : (mode_reg[`TCMC_STOP_BIT] & ld_b);
  wire dis_evt  = off_cmd
                | (wave ? (mode_reg[`TCMC_DIS_BIT] & cmp_c)
                        : (mode_reg[`TCMC_DIS_BIT] & ld_b));

  // ==========================================
  // Counter next value
  wire [CW-1:0] top = shape[1] ? hold_c_reg : `TCMC_CNT_MAX;
  wire          updn = wave & shape[0];
  reg  [CW-1:0] cv_next;           // Next counter value
  reg           down_next;         // Next direction

  always @* begin
    cv_next   = cv_reg;
    down_next = down_reg;
    if (trig && updn) begin
      // Updown shapes reverse direction on a trigger
      down_next = ~down_reg;
    end else if (trig) begin
      cv_next = {CW{1'b0}};
    end else if (tick && updn) begin
      if (!down_reg && (cv_reg >= top)) begin
        down_next = 1'b1;
        cv_next   = cv_reg - 1'b1;
      end else if (down_reg && (cv_reg == {CW{1'b0}})) begin
        down_next = 1'b0;
        cv_next   = cv_reg + 1'b1;
      end else begin
        cv_next = down_reg ? cv_reg - 1'b1 : cv_reg + 1'b1;
      end
    end else if (tick) begin
      cv_next = cv_reg + 1'b1;
    end
  end

  // ==========================================
  // Output line next levels
  reg ioa_next;                    // Next line_a level
  reg iob_next;                    // Next line_b level

  always @* begin
    ioa_next = io_line_a_out;
    iob_next = io_line_b_out;
    if (wave) begin
      // Later events in this order take precedence
      ioa_next = apply_act(ioa_next, mode_reg[17:16], cmp_a);
      ioa_next = apply_act(ioa_next, mode_reg[19:18], cmp_c);
      ioa_next = apply_act(ioa_next, mode_reg[21:20], evt);
      ioa_next = apply_act(ioa_next, mode_reg[23:22], sw_trg);
      if (!b_is_in) begin
        iob_next = apply_act(iob_next, mode_reg[25:24], cmp_b);
        iob_next = apply_act(iob_next, mode_reg[27:26], cmp_c);
        iob_next = apply_act(iob_next, mode_reg[29:28], evt);
        iob_next = apply_act(iob_next, mode_reg[31:30], sw_trg);
      end
    end
  end

  assign io_line_a_oe = wave;
  assign io_line_b_oe = wave & ~b_is_in;

  // ==========================================
  // Read mux
  reg [31:0] rd_word;              // Word for current address
  reg        rd_bad;               // Address not mapped

  always @* begin
    rd_word = 32'h00000000;
    rd_bad  = 1'b0;
    case (paddr)
      `TCMC_CMD_OFS:    rd_word = 32'h00000000;
      `TCMC_MODE_OFS:   rd_word = mode_reg;
      `TCMC_VALUE_OFS:  rd_word[CW-1:0] = cv_reg;
      `TCMC_HOLD_A_OFS: rd_word[CW-1:0] = hold_a_reg;
      `TCMC_HOLD_B_OFS: rd_word[CW-1:0] = hold_b_reg;
      `TCMC_HOLD_C_OFS: rd_word[CW-1:0] = hold_c_reg;
      `TCMC_STATUS_OFS: begin
        rd_word[`TCMC_ST_CLK_BIT] = clk_en_reg;
        rd_word[`TCMC_ST_IOA_BIT] = io_line_a_in;
        rd_word[`TCMC_ST_IOB_BIT] = io_line_b_in;
      end
      `TCMC_XSEL_OFS:   rd_word[5:0] = xsel_reg;
      default:          rd_bad = 1'b1;
    endcase
  end

  // ==========================================
  // Bus answer captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata  <= pwrite ? 32'h00000000 : rd_word;
      pslverr <= rd_bad;
    end
  end

  // ==========================================
  // Software-written registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg   <= `TCMC_MODE_RST;
      xsel_reg   <= `TCMC_XSEL_RST;
      hold_a_reg <= {CW{1'b0}};
      hold_b_reg <= {CW{1'b0}};
      hold_c_reg <= {CW{1'b0}};
    end else if (ce) begin
      if (wr_acc && paddr == `TCMC_MODE_OFS) begin
        mode_reg <= pwdata;
      end
      if (wr_acc && paddr == `TCMC_XSEL_OFS) begin
        xsel_reg <= pwdata[5:0];
      end
      if (wr_acc && paddr == `TCMC_HOLD_C_OFS) begin
        hold_c_reg <= pwdata[CW-1:0];
      end
      // Capture loads; software writes only in waveform view
      if (ld_a) begin
        hold_a_reg <= cv_reg;
      end else if (wave && wr_acc && paddr == `TCMC_HOLD_A_OFS) begin
        hold_a_reg <= pwdata[CW-1:0];
      end
      if (ld_b) begin
        hold_b_reg <= cv_reg;
      end else if (wave && wr_acc && paddr == `TCMC_HOLD_B_OFS) begin
        hold_b_reg <= pwdata[CW-1:0];
      end
    end
  end

  // ==========================================
  // Clock enable, stop and counter core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_reg    <= 1'b0;
      stop_reg      <= 1'b0;
      down_reg      <= 1'b0;
      step_reg      <= 1'b0;
      cv_reg        <= {CW{1'b0}};
      gclk_reg      <= 1'b0;
      ioa_reg       <= 1'b0;
      iob_reg       <= 1'b0;
      xc0_reg       <= 1'b0;
      xc1_reg       <= 1'b0;
      xc2_reg       <= 1'b0;
      io_line_a_out <= 1'b0;
      io_line_b_out <= 1'b0;
    end else if (ce) begin
      // Disable wins over an enable command in the same cycle
      if (dis_evt) begin
        clk_en_reg <= 1'b0;
      end else if (on_cmd) begin
        clk_en_reg <= 1'b1;
      end
      // Stop wins over a trigger in the same cycle
      if (stop_evt) begin
        stop_reg <= 1'b1;
      end else if (trig) begin
        stop_reg <= 1'b0;
      end
      cv_reg        <= cv_next;
      down_reg      <= down_next;
      step_reg      <= tick | trig;
      gclk_reg      <= gclk;
      ioa_reg       <= io_line_a_in;
      iob_reg       <= io_line_b_in;
      xc0_reg       <= ext_clk_0;
      xc1_reg       <= ext_clk_1;
      xc2_reg       <= ext_clk_2;
      io_line_a_out <= ioa_next;
      io_line_b_out <= iob_next;
    end
  end

endmodule

// ---- testbench/tcmc_chk.sv ----
// Port-level checker for the timer channel, bound to the design
`timescale 1ns/1ps
`include "tcmc_defines.vh"
module tcmc_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        io_line_a_out,
  input wire logic        io_line_a_oe,
  input wire logic        io_line_b_out,
  input wire logic        io_line_b_oe
);
  // ==========================================
  // Helper logic
  logic [31:0] mode_reg;                                   // Copy of the last mode written
  wire         wr     = psel && penable && pwrite && ce;   // Write taken
  wire         su     = psel && !penable && !pwrite && ce; // Read setup, read data latched
  wire         cmd_wr = wr && paddr == `TCMC_CMD_OFS;      // Command write
  wire         st_su  = su && paddr == `TCMC_STATUS_OFS;   // Status read starts
  // Mode copy follows taken writes only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 32'h00000000;
    end else if (wr && paddr == `TCMC_MODE_OFS) begin
      mode_reg <= pwdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Assertions
  oe_a_a: assert property (io_line_a_oe == mode_reg[15])
    else $error("line a drive does not follow mode");
  oe_b_a: assert property (io_line_b_oe == (mode_reg[15] && mode_reg[11:10] != 2'b00))
    else $error("line b drive does not follow event select");
  mode_rd_a: assert property (su && paddr == `TCMC_MODE_OFS |=> prdata == $past(mode_reg))
    else $error("mode read differs from written value");
  cmd_rd_a: assert property (su && paddr == `TCMC_CMD_OFS |=> prdata == 32'h00000000)
    else $error("command register read not zero");
  clk_on_a: assert property (cmd_wr && pwdata[1:0] == 2'b01 ##[1:2] st_su |=> prdata[16])
    else $error("clock not enabled by command");
  clk_off_a: assert property (cmd_wr && pwdata[1] ##[1:2] st_su |=> !prdata[16])
    else $error("clock not disabled by command");
  sw_set_a: assert property (cmd_wr && pwdata[2] && mode_reg[15] && mode_reg[23:22] == 2'b01
    |-> ##[1:2] io_line_a_out) else $error("line a not set by soft trigger");
  sw_clr_a: assert property (cmd_wr && pwdata[2] && mode_reg[15] && mode_reg[23:22] == 2'b10
    |-> ##[1:2] !io_line_a_out) else $error("line a not cleared by soft trigger");
  sw_b_a: assert property (cmd_wr && pwdata[2] && io_line_b_oe && mode_reg[31:30] == 2'b01
    |-> ##[1:2] io_line_b_out) else $error("line b not set by soft trigger");
  // Main scenarios reached
  cover property (cmd_wr && pwdata[2] && mode_reg[15]);
  cover property (cmd_wr && pwdata[1:0] == 2'b01 ##[1:2] st_su);
  cover property (wr && paddr == `TCMC_MODE_OFS && !pwdata[15]);
endmodule
bind tcmc_channel tcmc_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .io_line_a_out(io_line_a_out), .io_line_a_oe(io_line_a_oe),
  .io_line_b_out(io_line_b_out), .io_line_b_oe(io_line_b_oe));

// ---- testbench/tcmc_pins.sv ----
// Far-side pin model: clock sources and channel lines
`timescale 1ns/1ps
module tcmc_pins (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] run,
  input  wire logic        io_line_a_out,
  input  wire logic        io_line_a_oe,
  input  wire logic        io_line_b_out,
  input  wire logic        io_line_b_oe,
  output wire logic [4:0]  internal_clk,
  output wire logic        ext_clk_0,
  output wire logic        clock_pin_1,
  output wire logic        clock_pin_2,
  output wire logic        io_a_ch0,
  output wire logic        io_a_ch1,
  output wire logic        io_a_ch2,
  output wire logic        io_line_a_in,
  output wire logic        io_line_b_in
);
  logic [11:0] lvl_reg;  // Source levels; a stopped source rests low
  // Running sources toggle each cycle, stopped ones fall
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_reg <= 12'h000;
    end else begin
      lvl_reg <= run & ~lvl_reg;
    end
  end
  assign internal_clk = lvl_reg[4:0];
  assign ext_clk_0    = lvl_reg[5];
  assign clock_pin_1  = lvl_reg[6];
  assign clock_pin_2  = lvl_reg[7];
  assign io_a_ch0     = lvl_reg[8];
  assign io_a_ch1     = lvl_reg[9];
  assign io_a_ch2     = lvl_reg[10];
  // Wire level: the channel wins while it drives
  assign io_line_a_in = io_line_a_oe ? io_line_a_out : lvl_reg[11];
  assign io_line_b_in = io_line_b_oe ? io_line_b_out : ~lvl_reg[11];
endmodule

// ---- testbench/tb_timer_channel_mode_control.sv ----
// Self-checking bench of the timer channel
`timescale 1ns/1ps
`include "tcmc_defines.vh"
`define CHK(nm, got, ex) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module tb_timer_channel_mode_control;
  logic        pclk, presetn, ce, psel, penable, pwrite;  // Bus and clock drives
  logic [7:0]  paddr;                                     // Bus address
  logic [31:0] pwdata, rd, m;                             // Write data, read data, mode
  logic        err, exp;                                  // Error seen, expected line level
  logic [11:0] run;                                       // Sources the pin model toggles
  wire  [31:0] prdata;
  wire         pready, pslverr, ext_clk_0, clock_pin_1, clock_pin_2;
  wire         io_a_ch0, io_a_ch1, io_a_ch2, a_in, a_out, a_oe, b_in, b_out, b_oe;
  wire  [4:0]  internal_clk;
  int          bad_count, samples_checked, cyc;
  int          cmds [4] = '{3, 1, 0, 2};
  int          ens [4] = '{0, 1, 1, 0};
  int          codes [5] = '{1, 2, 3, 3, 0};
  tcmc_channel dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .internal_clk(internal_clk), .ext_clk_0(ext_clk_0),
    .clock_pin_1(clock_pin_1), .clock_pin_2(clock_pin_2), .io_a_ch0(io_a_ch0),
    .io_a_ch1(io_a_ch1), .io_a_ch2(io_a_ch2), .io_line_a_in(a_in), .io_line_a_out(a_out),
    .io_line_a_oe(a_oe), .io_line_b_in(b_in), .io_line_b_out(b_out), .io_line_b_oe(b_oe));
  tcmc_pins u_pins (.pclk(pclk), .presetn(presetn), .run(run), .io_line_a_out(a_out),
    .io_line_a_oe(a_oe), .io_line_b_out(b_out), .io_line_b_oe(b_oe),
    .internal_clk(internal_clk), .ext_clk_0(ext_clk_0), .clock_pin_1(clock_pin_1),
    .clock_pin_2(clock_pin_2), .io_a_ch0(io_a_ch0), .io_a_ch1(io_a_ch1), .io_a_ch2(io_a_ch2),
    .io_line_a_in(a_in), .io_line_b_in(b_in));
  // ==========================================
  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ==========================================
  // Tasks
  task give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Configure, trigger, then see whether the counter moves
  task clk_case(input logic [31:0] md, xs, input logic [11:0] s, input logic mv, en);
    logic [31:0] c0;
    run <= 12'h000;
    apb(1'b1, `TCMC_XSEL_OFS, xs);
    apb(1'b1, `TCMC_MODE_OFS, md);
    apb(1'b1, `TCMC_CMD_OFS, 32'h00000005);
    apb(1'b0, `TCMC_VALUE_OFS, 32'h0);
    `CHK("count_reset", rd, 32'h00000000)
    run <= s;
    repeat (12) @(posedge pclk);
    apb(1'b0, `TCMC_VALUE_OFS, 32'h0);
    c0 = rd;
    repeat (12) @(posedge pclk);
    apb(1'b0, `TCMC_VALUE_OFS, 32'h0);
    `CHK("count_moves", (rd !== c0), mv)
    apb(1'b0, `TCMC_STATUS_OFS, 32'h0);
    `CHK("clock_enabled", rd[`TCMC_ST_CLK_BIT], en)
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run} = '0;
    ce = 1'b1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TCMC_MODE_OFS, 32'h0);
    `CHK("mode_reset", rd, `TCMC_MODE_RST)
    apb(1'b0, 8'h08, 32'h0);
    `CHK("unmapped_err", err, 1'b1)
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `TCMC_CMD_OFS, cmds[i]);
      apb(1'b0, `TCMC_STATUS_OFS, 32'h0);
      `CHK("clock_cmd", rd[`TCMC_ST_CLK_BIT], ens[i][0])
    end
    $display("test commands done");
    apb(1'b1, `TCMC_HOLD_C_OFS, 32'h00000003);
    clk_case(32'h0, 32'h0, 12'h001, 1'b1, 1'b1);
    clk_case(32'h4, 32'h0, 12'h010, 1'b1, 1'b1);
    clk_case(32'h4, 32'h0, 12'h001, 1'b0, 1'b1);
    clk_case(32'h5, 32'h0, 12'h020, 1'b1, 1'b1);
    clk_case(32'h6, 32'h0, 12'h040, 1'b1, 1'b1);
    clk_case(32'h6, 32'h4, 12'h040, 1'b0, 1'b1);
    clk_case(32'h6, 32'h8, 12'h100, 1'b1, 1'b1);
    clk_case(32'h6, 32'hC, 12'h400, 1'b1, 1'b1);
    clk_case(32'h7, 32'h30, 12'h200, 1'b1, 1'b1);
    clk_case(32'h7, 32'h0, 12'h080, 1'b1, 1'b1);
    clk_case(32'h10, 32'h0, 12'h001, 1'b0, 1'b1);
    clk_case(32'h10, 32'h0, 12'h021, 1'b1, 1'b1);
    clk_case(32'h40080, 32'h0, 12'h801, 1'b0, 1'b0);
    clk_case(32'h40040, 32'h0, 12'h801, 1'b0, 1'b1);
    clk_case(32'h8040, 32'h0, 12'h001, 1'b0, 1'b1);
    clk_case(32'h8080, 32'h0, 12'h001, 1'b0, 1'b0);
    $display("test clocks done");
    run <= 12'h000;
    exp = 1'b0;
    // Compare c or line_a rising edge keeps restarting the count
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `TCMC_MODE_OFS, i ? 32'h00000500 : 32'h00004000);
      apb(1'b1, `TCMC_CMD_OFS, 32'h00000005);
      run <= 12'h801;
      repeat (40) @(posedge pclk);
      apb(1'b0, `TCMC_VALUE_OFS, 32'h0);
      `CHK("trigger_bound", (rd <= 32'h00000003), 1'b1)
      run <= 12'h000;
    end
    $display("test triggers done");
    for (int i = 0; i < 5; i++) begin
      m = 32'h00008400 | (codes[i] << 22) | (codes[i] << 30);
      apb(1'b1, `TCMC_MODE_OFS, m);
      apb(1'b0, `TCMC_MODE_OFS, 32'h0);
      `CHK("mode_read", rd, m)
      apb(1'b1, `TCMC_CMD_OFS, 32'h00000004);
      repeat (2) @(posedge pclk);
      #10;
      exp = (codes[i] == 1) ? 1'b1 : (codes[i] == 2) ? 1'b0 : (codes[i] == 3) ? ~exp : exp;
      `CHK("line_a", a_out, exp)
      `CHK("line_b", b_out, exp)
      `CHK("line_b_drive", b_oe, 1'b1)
    end
    apb(1'b1, `TCMC_MODE_OFS, 32'h00008000);
    #10;
    `CHK("line_b_input", b_oe, 1'b0)
    `CHK("line_a_drive", a_oe, 1'b1)
    // A write while the clock enable is low must be lost
    ce <= 1'b0;
    apb(1'b1, `TCMC_MODE_OFS, 32'h00000000);
    ce <= 1'b1;
    apb(1'b0, `TCMC_MODE_OFS, 32'h0);
    `CHK("mode_frozen", rd, 32'h00008000)
    $display("test outputs done");
    give_verdict();
  end
endmodule
